//--- src/i2c_opt_pkg.sv
// constants for the i2c slave option and status block
// assumes an 8-bit register port with a 3-bit word index
package i2c_opt_pkg;

  // register indices on the plain register port
  localparam logic [2:0] OFF_OPTION      = 3'h0;
  localparam logic [2:0] OFF_CONTROL_ONE = 3'h1;
  localparam logic [2:0] OFF_BUFFER      = 3'h2;
  localparam logic [2:0] OFF_ADDRESS     = 3'h3;
  localparam logic [2:0] OFF_IRQ_STATUS  = 3'h4;
  localparam logic [2:0] OFF_IRQ_MASK    = 3'h5;
  localparam logic [2:0] OFF_REQUEST     = 3'h6;
  localparam logic [2:0] OFF_STATUS      = 3'h7;

  // option control fields
  localparam int OPT_ACK_PHASE  = 7;
  localparam int OPT_COLL_DET   = 2;
  localparam int OPT_ADDR_HOLD  = 1;
  localparam int OPT_DATA_HOLD  = 0;
  localparam int OPT_OVERWRITE  = 4;
  localparam logic [6:0] OPTION_RESET = 7'h00;

  // port control one fields
  localparam int CTL_CLOCK_RELEASE = 4;
  localparam int CTL_ENABLE        = 5;
  localparam logic CLOCK_RELEASE_RESET = 1'b1;
  localparam logic ENABLE_RESET        = 1'b0;

  // interrupt status and mask fields
  localparam int IRQ_WIDTH     = 4;
  localparam int IRQ_BYTE      = 0;
  localparam int IRQ_COLLISION = 1;
  localparam int IRQ_HOLD      = 2;
  localparam int IRQ_STOP      = 3;
  localparam logic [3:0] IRQ_RESET = 4'h0;

  // status fields
  localparam int STAT_BUSY        = 0;
  localparam int STAT_BUFFER_FULL = 1;
  localparam int STAT_OVERFLOW    = 2;
  localparam int STAT_READ        = 3;

  // master sequence requests: ack, receive, stop, restart, start
  localparam int REQ_WIDTH = 5;
  localparam logic [4:0] REQ_RESET = 5'h00;

  localparam logic [7:0] BYTE_RESET    = 8'h00;
  localparam logic [3:0] BIT_LAST      = 4'h8;
  localparam logic [3:0] BIT_ACK       = 4'h9;
  localparam logic [3:0] BIT_FIRST     = 4'h0;

  typedef enum {ST_IDLE, ST_ADDR, ST_RX, ST_TX, ST_SKIP} link_state_t;

endpackage

//--- src/i2c_slave_option_control.sv
// i2c slave option control: clock stretching, ack phase flag, collision
// assumes open-drain scl/sda resolved outside; link clock slower than clk_i
// Summary of operation
// R1: master sequence requests written while the port is busy are dropped, never queued
// R2: shift buffer writes while the port is busy are ignored
// R3: read-only ack phase flag, reset zero, set on eighth falling scl edge
// R4: address hold: matching address byte clears clock release and holds scl low
// R5: collision detect: sda low on scl rise while sending high raises collision flag
// R6: ack phase flag works only with address hold or data hold enabled
// R7: data hold: received data byte clears clock release and stretches scl low
`timescale 1ns/1ns
module i2c_slave_option_control (
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  input  wire logic [2:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_we_i,
  input  wire logic        reg_re_i,
  output logic      [7:0]  reg_rdata_o,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe_o,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o,
  output logic             irq_o
);
  import i2c_opt_pkg::*;

  logic scl_lvl, scl_rise, scl_fall;
  logic sda_lvl, sda_rise, sda_fall;

  pin_sync u_scl_sync (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .pin_i    (scl_i),
    .level_o  (scl_lvl),
    .rise_o   (scl_rise),
    .fall_o   (scl_fall)
  );

  pin_sync u_sda_sync (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .pin_i    (sda_i),
    .level_o  (sda_lvl),
    .rise_o   (sda_rise),
    .fall_o   (sda_fall)
  );

  // register file state
  logic [6:0]           option_reg,  option_next;
  logic                 ack_phase_reg, ack_phase_next;
  logic                 release_reg, release_next;
  logic                 enable_reg,  enable_next;
  logic [7:0]           buffer_reg,  buffer_next;
  logic [7:0]           address_reg, address_next;
  logic [IRQ_WIDTH-1:0] irq_stat_reg, irq_stat_next;
  logic [IRQ_WIDTH-1:0] irq_mask_reg, irq_mask_next;
  logic [REQ_WIDTH-1:0] request_reg, request_next;
  logic                 full_reg,    full_next;
  logic                 overflow_reg, overflow_next;
  logic [7:0]           rdata_reg,   rdata_next;
  // link state
  link_state_t          state_reg,   state_next;
  logic [3:0]           bit_cnt_reg, bit_cnt_next;
  logic [7:0]           shift_reg,   shift_next;
  logic                 read_reg,    read_next;
  logic                 sda_low_reg, sda_low_next;
  logic                 tx_high_reg, tx_high_next;

  logic busy;
  logic start_seen;
  logic stop_seen;
  logic hold_on;
  logic addr_match;
  logic link_go;
  logic [7:0] status_word;

  // bus conditions are judged on the synchronised levels only
  assign busy        = (state_reg != ST_IDLE);
  assign start_seen  = sda_fall & scl_lvl;
  assign stop_seen   = sda_rise & scl_lvl;
  assign hold_on     = option_reg[OPT_ADDR_HOLD] | option_reg[OPT_DATA_HOLD];
  assign addr_match  = (shift_reg[7:1] == address_reg[7:1]);
  assign link_go     = enable_reg & ~start_seen & ~stop_seen;
  assign status_word = {4'h0, read_reg, overflow_reg, full_reg, busy};

  // software side first, link side after so hardware events win
  always_comb begin
    option_next    = option_reg;
    ack_phase_next = ack_phase_reg;
    release_next   = release_reg;
    enable_next    = enable_reg;
    buffer_next    = buffer_reg;
    address_next   = address_reg;
    irq_stat_next  = irq_stat_reg;
    irq_mask_next  = irq_mask_reg;
    request_next   = request_reg;
    full_next      = full_reg;
    overflow_next  = overflow_reg;
    rdata_next     = BYTE_RESET;
    state_next     = state_reg;
    bit_cnt_next   = bit_cnt_reg;
    shift_next     = shift_reg;
    read_next      = read_reg;
    sda_low_next   = sda_low_reg;
    tx_high_next   = tx_high_reg;

    if (reg_we_i) begin
      case (reg_addr_i)
        OFF_OPTION:      option_next = reg_wdata_i[6:0];
        OFF_CONTROL_ONE: begin
          release_next = reg_wdata_i[CTL_CLOCK_RELEASE];
          enable_next  = reg_wdata_i[CTL_ENABLE];
        end
        OFF_BUFFER: begin
          if (!busy) begin
            buffer_next = reg_wdata_i; // R2
          end
        end
        OFF_ADDRESS:     address_next = reg_wdata_i;
        OFF_IRQ_STATUS:  irq_stat_next = irq_stat_reg & ~reg_wdata_i[IRQ_WIDTH-1:0];
        OFF_IRQ_MASK:    irq_mask_next = reg_wdata_i[IRQ_WIDTH-1:0];
        OFF_REQUEST: begin
          // no spooling: a busy port simply drops the request
          if (!busy) begin
            request_next = reg_wdata_i[REQ_WIDTH-1:0]; // R1
          end
        end
        default: ;
      endcase
    end

    // read data appears one cycle after the strobe
    if (reg_re_i) begin
      case (reg_addr_i)
        OFF_OPTION:      rdata_next = {ack_phase_reg, option_reg};
        OFF_CONTROL_ONE: rdata_next = {2'h0, enable_reg, release_reg, 4'h0};
        OFF_BUFFER: begin
          rdata_next = buffer_reg;
          full_next  = 1'b0;
        end
        OFF_ADDRESS:     rdata_next = address_reg;
        OFF_IRQ_STATUS:  rdata_next = {4'h0, irq_stat_reg};
        OFF_IRQ_MASK:    rdata_next = {4'h0, irq_mask_reg};
        OFF_REQUEST:     rdata_next = {3'h0, request_reg};
        OFF_STATUS:      rdata_next = status_word;
        default:         rdata_next = BYTE_RESET;
      endcase
    end

    if (!enable_reg) begin
      state_next     = ST_IDLE;
      sda_low_next   = 1'b0;
      tx_high_next   = 1'b0;
      ack_phase_next = 1'b0;
    end else if (start_seen) begin
      // a repeated start is taken like a first one
      state_next     = ST_ADDR;
      bit_cnt_next   = BIT_FIRST;
      sda_low_next   = 1'b0;
      tx_high_next   = 1'b0;
      ack_phase_next = 1'b0;
    end else if (stop_seen) begin
      state_next              = ST_IDLE;
      sda_low_next            = 1'b0;
      tx_high_next            = 1'b0;
      ack_phase_next          = 1'b0;
      irq_stat_next[IRQ_STOP] = 1'b1;
    end else begin
      case (state_reg)
        ST_ADDR, ST_RX: begin
          if (scl_rise && bit_cnt_reg < BIT_LAST) begin
            shift_next   = {shift_reg[6:0], sda_lvl};
            bit_cnt_next = 4'(bit_cnt_reg + 4'h1);
          end else if (scl_fall && bit_cnt_reg == BIT_LAST) begin
            bit_cnt_next   = BIT_ACK;
            ack_phase_next = hold_on; // R3 R6
            if (state_reg == ST_ADDR) begin
              if (addr_match) begin
                sda_low_next = 1'b1;
                read_next    = shift_reg[0];
                if (option_reg[OPT_ADDR_HOLD]) begin
                  release_next            = 1'b0; // R4
                  irq_stat_next[IRQ_HOLD] = 1'b1;
                end
              end else begin
                state_next     = ST_SKIP;
                ack_phase_next = 1'b0;
              end
            end else begin
              // a full buffer keeps its byte unless overwrite is allowed
              if (full_reg && !option_reg[OPT_OVERWRITE]) begin
                overflow_next = 1'b1;
              end else begin
                buffer_next = shift_reg;
                full_next   = 1'b1;
              end
              sda_low_next            = 1'b1;
              irq_stat_next[IRQ_BYTE] = 1'b1;
              if (option_reg[OPT_DATA_HOLD]) begin
                release_next            = 1'b0; // R7
                irq_stat_next[IRQ_HOLD] = 1'b1;
              end
            end
          end else if (scl_fall && bit_cnt_reg == BIT_ACK) begin
            ack_phase_next = 1'b0;
            bit_cnt_next   = BIT_FIRST;
            sda_low_next   = 1'b0;
            if (state_reg == ST_ADDR && read_reg) begin
              state_next   = ST_TX;
              shift_next   = buffer_reg;
              full_next    = 1'b0;
              sda_low_next = ~buffer_reg[7];
              tx_high_next = buffer_reg[7];
            end else begin
              state_next = ST_RX;
            end
          end
        end
        ST_TX: begin
          if (scl_rise && bit_cnt_reg < BIT_LAST) begin
            bit_cnt_next = 4'(bit_cnt_reg + 4'h1);
            // we let sda float high but the wire reads low
            if (tx_high_reg && !sda_lvl && option_reg[OPT_COLL_DET]) begin
              irq_stat_next[IRQ_COLLISION] = 1'b1; // R5
              state_next                   = ST_SKIP;
              sda_low_next                 = 1'b0;
              tx_high_next                 = 1'b0;
            end
          end else if (scl_rise && bit_cnt_reg == BIT_ACK && sda_lvl) begin
            state_next     = ST_SKIP; // master refused further bytes
            ack_phase_next = 1'b0;
          end else if (scl_fall && bit_cnt_reg < BIT_LAST) begin
            shift_next   = {shift_reg[6:0], 1'b0};
            sda_low_next = ~shift_reg[6];
            tx_high_next = shift_reg[6];
          end else if (scl_fall && bit_cnt_reg == BIT_LAST) begin
            bit_cnt_next   = BIT_ACK;
            sda_low_next   = 1'b0;
            tx_high_next   = 1'b0;
            ack_phase_next = hold_on; // R3 R6
            irq_stat_next[IRQ_BYTE] = 1'b1;
          end else if (scl_fall && bit_cnt_reg == BIT_ACK) begin
            ack_phase_next = 1'b0;
            bit_cnt_next   = BIT_FIRST;
            shift_next     = buffer_reg;
            full_next      = 1'b0;
            sda_low_next   = ~buffer_reg[7];
            tx_high_next   = buffer_reg[7];
          end
        end
        ST_SKIP: ; // wait for stop or restart
        default: state_next = ST_IDLE;
      endcase
    end
  end

  // all state registered here; reset loads constants only
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      option_reg    <= OPTION_RESET;
      ack_phase_reg <= 1'b0;
      release_reg   <= CLOCK_RELEASE_RESET;
      enable_reg    <= ENABLE_RESET;
      buffer_reg    <= BYTE_RESET;
      address_reg   <= BYTE_RESET;
      irq_stat_reg  <= IRQ_RESET;
      irq_mask_reg  <= IRQ_RESET;
      request_reg   <= REQ_RESET;
      full_reg      <= 1'b0;
      overflow_reg  <= 1'b0;
      rdata_reg     <= BYTE_RESET;
      state_reg     <= ST_IDLE;
      bit_cnt_reg   <= BIT_FIRST;
      shift_reg     <= BYTE_RESET;
      read_reg      <= 1'b0;
      sda_low_reg   <= 1'b0;
      tx_high_reg   <= 1'b0;
    end else begin
      option_reg    <= option_next;
      ack_phase_reg <= ack_phase_next;
      release_reg   <= release_next;
      enable_reg    <= enable_next;
      buffer_reg    <= buffer_next;
      address_reg   <= address_next;
      irq_stat_reg  <= irq_stat_next;
      irq_mask_reg  <= irq_mask_next;
      request_reg   <= request_next;
      full_reg      <= full_next;
      overflow_reg  <= overflow_next;
      rdata_reg     <= rdata_next;
      state_reg     <= state_next;
      bit_cnt_reg   <= bit_cnt_next;
      shift_reg     <= shift_next;
      read_reg      <= read_next;
      sda_low_reg   <= sda_low_next;
      tx_high_reg   <= tx_high_next;
    end
  end

  // open-drain pins: only ever pull low
  assign scl_o       = 1'b0;
  assign scl_oe_o    = enable_reg & ~release_reg; // R4 R7
  assign sda_o       = 1'b0;
  assign sda_oe_o    = sda_low_reg;
  assign reg_rdata_o = rdata_reg;
  assign irq_o       = |(irq_stat_reg & irq_mask_reg);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  chk_request_drop: assert property ( // R1
    busy && reg_we_i && reg_addr_i == OFF_REQUEST |=> request_reg == $past(request_reg))
    else $error("request accepted while port busy");

  chk_buffer_lock: assert property ( // R2
    busy && reg_we_i && reg_addr_i == OFF_BUFFER && !(scl_fall && bit_cnt_reg == BIT_LAST)
    |=> buffer_reg == $past(buffer_reg))
    else $error("shift buffer written while port busy");

  chk_ack_phase_edge: assert property ( // R3
    $rose(ack_phase_reg) |-> $past(scl_fall) && $past(bit_cnt_reg) == BIT_LAST)
    else $error("ack phase flag rose off the eighth falling edge");

  chk_addr_hold: assert property ( // R4
    state_reg == ST_ADDR && link_go && scl_fall && bit_cnt_reg == BIT_LAST && addr_match && option_reg[OPT_ADDR_HOLD]
    && !(reg_we_i && reg_addr_i == OFF_CONTROL_ONE) |=> !release_reg && scl_oe_o && sda_oe_o)
    else $error("matching address did not hold scl");

  chk_collision_flag: assert property ( // R5
    state_reg == ST_TX && link_go && scl_rise && bit_cnt_reg < BIT_LAST && tx_high_reg
    && !sda_lvl && option_reg[OPT_COLL_DET] |=> irq_stat_reg[IRQ_COLLISION] ##1 !sda_oe_o)
    else $error("slave collision not flagged");

  chk_collision_quiet: assert property ( // R5
    !option_reg[OPT_COLL_DET] |=> !$rose(irq_stat_reg[IRQ_COLLISION]))
    else $error("collision flagged with detection disabled");

  chk_ack_phase_gate: assert property ( // R6
    $rose(ack_phase_reg) |-> $past(hold_on))
    else $error("ack phase flag set with both holds disabled");

  chk_data_hold: assert property ( // R7
    state_reg == ST_RX && link_go && scl_fall && bit_cnt_reg == BIT_LAST
    && option_reg[OPT_DATA_HOLD] && !(reg_we_i && reg_addr_i == OFF_CONTROL_ONE)
    |=> !release_reg && scl_oe_o ##1 scl_oe_o || release_reg)
    else $error("received data byte did not stretch scl");

endmodule

//--- src/pin_sync.sv
// two-stage synchroniser with edge detection for one bus pin
// assumes the pin is asynchronous to clk_i and slower than clk_i
`timescale 1ns/1ns
module pin_sync (
  input  wire logic clk_i,
  input  wire logic arst_n_i,
  input  wire logic pin_i,
  output logic      level_o,
  output logic      rise_o,
  output logic      fall_o
);

  logic meta_reg;
  logic stable_reg;
  logic last_reg;

  // meta_reg feeds only stable_reg; edges come from later stages
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_reg   <= 1'b1;
      stable_reg <= 1'b1;
      last_reg   <= 1'b1;
    end else begin
      meta_reg   <= pin_i;
      stable_reg <= meta_reg;
      last_reg   <= stable_reg;
    end
  end

  // released bus idles high, so reset to one gives no false edge
  assign level_o = stable_reg;
  assign rise_o  = stable_reg & ~last_reg;
  assign fall_o  = ~stable_reg & last_reg;

endmodule

//--- tb/i2c_master_model.sv
// i2c bus master model: drives scl and sda open-drain, waits out clock stretching
// assumes the bench resolves both wires with pull-ups from every party's enable
`timescale 1ns/1ns
module i2c_master_model (
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      scl_low_o,
  output logic      sda_low_o,
  output logic      stuck_o
);
  // idle: both lines released, scl stands still between frames
  initial begin
    scl_low_o = 1'b0;
    sda_low_o = 1'b0;
    stuck_o   = 1'b0;
  end

  // one bit: data changes only while scl is low, sampled in the high phase
  task automatic bit_io(input logic b, output logic r);
    int n;
    sda_low_o = ~b;
    #100 scl_low_o = 1'b0;
    n = 0;
    // a stretching slave keeps scl low; bounded so a stuck hold cannot hang the run
    while (scl_i !== 1'b1 && n < 400) begin
      #50 n++;
    end
    if (n >= 400) stuck_o = 1'b1;
    #100 r = sda_i;
    #100 scl_low_o = 1'b1;
    #100;
  endtask

  // whole byte, msb first
  task automatic byte_io(input logic [7:0] d, output logic [7:0] q);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
  endtask

  // start: sda falls while scl is high
  task automatic start_cond();
    sda_low_o = 1'b0;
    scl_low_o = 1'b0;
    #200 sda_low_o = 1'b1;
    #200 scl_low_o = 1'b1;
    #100;
  endtask

  // stop: sda rises while scl is high, then both lines stay released
  task automatic stop_cond();
    sda_low_o = 1'b1;
    #100 scl_low_o = 1'b0;
    #200 sda_low_o = 1'b0;
    #200;
  endtask
endmodule

//--- tb/tb_top.sv
// self-checking bench for the i2c slave option control block
// assumes the master model in i2c_master_model.sv and pull-ups on scl and sda
`timescale 1ns/1ns
module tb_top;
  import i2c_opt_pkg::*;
  logic       clk_i;
  logic       arst_n_i;
  logic [2:0] reg_addr_i;
  logic [7:0] reg_wdata_i;
  logic       reg_we_i;
  logic       reg_re_i;
  logic [7:0] reg_rdata_o;
  logic       scl_o;
  logic       scl_oe_o;
  logic       sda_o;
  logic       sda_oe_o;
  logic       irq_o;
  logic       m_scl_low;
  logic       m_sda_low;
  logic       m_stuck;
  wire        scl_w;
  wire        sda_w;
  logic [7:0] q;
  logic       a;
  int         n_fail;
  int         num_checks;

  // 20 MHz system clock
  initial clk_i = 1'b0;
  always #25 clk_i = ~clk_i;

  // open-drain wires: low while any party pulls, else the pull-up wins
  assign scl_w = !(scl_oe_o && !scl_o) && !m_scl_low;
  assign sda_w = !(sda_oe_o && !sda_o) && !m_sda_low;

  i2c_slave_option_control DUT (
    .clk_i       (clk_i),
    .arst_n_i    (arst_n_i),
    .reg_addr_i  (reg_addr_i),
    .reg_wdata_i (reg_wdata_i),
    .reg_we_i    (reg_we_i),
    .reg_re_i    (reg_re_i),
    .reg_rdata_o (reg_rdata_o),
    .scl_i       (scl_w),
    .scl_o       (scl_o),
    .scl_oe_o    (scl_oe_o),
    .sda_i       (sda_w),
    .sda_o       (sda_o),
    .sda_oe_o    (sda_oe_o),
    .irq_o       (irq_o)
  );

  i2c_master_model m (
    .scl_i     (scl_w),
    .sda_i     (sda_w),
    .scl_low_o (m_scl_low),
    .sda_low_o (m_sda_low),
    .stuck_o   (m_stuck)
  );

  // verdict and end of run
  task automatic summarize();
    if (n_fail == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // single compare for all byte and flag results
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one-cycle write; the trailing delay lets the register update land
  task automatic wr(input logic [2:0] ad, input logic [7:0] d);
    @(posedge clk_i);
    reg_we_i    <= 1'b1;
    reg_addr_i  <= ad;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_we_i    <= 1'b0;
    #1;
  endtask

  // one-cycle read, data taken in the following cycle only, then compared under a mask
  task automatic rchk(input logic [2:0] ad, input logic [7:0] msk, input logic [7:0] exp, input string name);
    @(posedge clk_i);
    reg_re_i   <= 1'b1;
    reg_addr_i <= ad;
    @(posedge clk_i);
    reg_re_i   <= 1'b0;
    #1;
    chk(name, exp, reg_rdata_o & msk);
    // read data stand one cycle only, then drop to zero
    @(posedge clk_i);
    #1;
    chk(name, 8'h00, reg_rdata_o);
  endtask

  // reset values, read-only flag, requests accepted while idle
  task automatic t_reset();
    rchk(OFF_OPTION, 8'hFF, 8'h00, "option_rst");
    rchk(OFF_CONTROL_ONE, 8'h30, 8'h10, "control_rst");
    wr(OFF_OPTION, 8'hFF);
    rchk(OFF_OPTION, 8'hFF, 8'h7F, "option_ro");
    wr(OFF_REQUEST, 8'h01);
    rchk(OFF_REQUEST, 8'hFF, 8'h01, "request_idle");
    wr(OFF_REQUEST, 8'h00);
    wr(OFF_OPTION, 8'h00);
  endtask

  // read transfer, no holds, no detection: busy buffer write dropped, master clash unseen
  task automatic t_read_plain();
    wr(OFF_CONTROL_ONE, 8'h30);
    wr(OFF_ADDRESS, 8'hA0);
    wr(OFF_BUFFER, 8'hC3);
    m.start_cond();
    wr(OFF_BUFFER, 8'h3C);
    m.byte_io(8'hA1, q);
    repeat (6) @(posedge clk_i);
    rchk(OFF_OPTION, 8'h80, 8'h00, "ack_flag_idle");
    rchk(OFF_STATUS, 8'h0F, 8'h09, "status_read");
    m.bit_io(1'b1, a);
    chk("addr_ack", 8'h00, {7'h00, a});
    m.byte_io(8'h7F, q);
    chk("tx_byte", 8'h43, q);
    m.bit_io(1'b1, a);
    m.stop_cond();
    rchk(OFF_IRQ_STATUS, 8'h02, 8'h00, "no_collision");
  endtask

  // read transfer with detection: clash on the first bit, then irq mask and clear
  task automatic t_read_collision();
    wr(OFF_OPTION, 8'h04);
    wr(OFF_BUFFER, 8'hC3);
    m.start_cond();
    m.byte_io(8'hA1, q);
    m.bit_io(1'b1, a);
    m.byte_io(8'h7F, q);
    chk("sda_released", 8'h7F, q);
    m.bit_io(1'b1, a);
    m.stop_cond();
    rchk(OFF_IRQ_STATUS, 8'h02, 8'h02, "collision_flag");
    wr(OFF_IRQ_MASK, 8'h00);
    chk("irq_masked", 8'h00, {7'h00, irq_o});
    wr(OFF_IRQ_MASK, 8'h02);
    chk("irq_raised", 8'h01, {7'h00, irq_o});
    wr(OFF_IRQ_STATUS, 8'h0F);
    chk("irq_cleared", 8'h00, {7'h00, irq_o});
    wr(OFF_OPTION, 8'h00);
  endtask

  // write transfer with address and data hold; requests refused while busy
  task automatic t_write_hold();
    wr(OFF_OPTION, 8'h03);
    m.start_cond();
    m.byte_io(8'hA0, q);
    repeat (6) @(posedge clk_i);
    #1;
    chk("scl_held_addr", 8'h01, {7'h00, scl_oe_o});
    rchk(OFF_OPTION, 8'hFF, 8'h83, "ack_flag_addr");
    rchk(OFF_CONTROL_ONE, 8'h30, 8'h20, "release_addr");
    wr(OFF_REQUEST, 8'h1F);
    rchk(OFF_REQUEST, 8'hFF, 8'h00, "request_busy");
    wr(OFF_CONTROL_ONE, 8'h30);
    m.bit_io(1'b1, a);
    chk("addr_ack_w", 8'h00, {7'h00, a});
    repeat (6) @(posedge clk_i);
    rchk(OFF_OPTION, 8'h80, 8'h00, "ack_flag_end");
    m.byte_io(8'h5A, q);
    repeat (6) @(posedge clk_i);
    #1;
    chk("scl_held_data", 8'h01, {7'h00, scl_oe_o});
    rchk(OFF_CONTROL_ONE, 8'h30, 8'h20, "release_data");
    rchk(OFF_OPTION, 8'h80, 8'h80, "ack_flag_data");
    wr(OFF_CONTROL_ONE, 8'h30);
    m.bit_io(1'b1, a);
    chk("data_ack", 8'h00, {7'h00, a});
    m.stop_cond();
    rchk(OFF_BUFFER, 8'hFF, 8'h5A, "rx_byte");
    rchk(OFF_IRQ_STATUS, 8'h0F, 8'h0D, "irq_events");
  endtask

  // received bytes meeting a full buffer: kept first, overwritten once allowed
  task automatic t_rx_buffer();
    for (int k = 0; k < 2; k++) begin
      wr(OFF_OPTION, k ? 8'h10 : 8'h00);
      m.start_cond();
      m.byte_io(8'hA0, q);
      rchk(OFF_STATUS, 8'h01, 8'h01, "status_busy");
      m.bit_io(1'b1, a);
      m.byte_io(k ? 8'h33 : 8'h11, q);
      m.bit_io(1'b1, a);
      m.byte_io(k ? 8'h44 : 8'h22, q);
      m.bit_io(1'b1, a);
      m.stop_cond();
      rchk(OFF_STATUS, 8'h0F, 8'h06, "status_full_over");
      rchk(OFF_BUFFER, 8'hFF, k ? 8'h44 : 8'h11, "rx_buffer");
    end
  endtask

  // no acknowledge for another address, nor for our own while the port is off
  task automatic t_no_ack();
    for (int k = 0; k < 2; k++) begin
      if (k) wr(OFF_CONTROL_ONE, 8'h10);
      m.start_cond();
      m.byte_io(k ? 8'hA0 : 8'hB0, q);
      m.bit_io(1'b1, a);
      chk("no_ack", 8'h01, {7'h00, a});
      m.stop_cond();
    end
  endtask

  // main sequence: inputs set at time zero, reset for three cycles
  initial begin
    n_fail      = 0;
    num_checks  = 0;
    arst_n_i    = 1'b0;
    reg_addr_i  = 3'h0;
    reg_wdata_i = 8'h00;
    reg_we_i    = 1'b0;
    reg_re_i    = 1'b0;
    repeat (3) @(posedge clk_i);
    arst_n_i <= 1'b1;
    t_reset();
    t_read_plain();
    t_read_collision();
    t_write_hold();
    t_rx_buffer();
    t_no_ack();
    chk("stretch_timeout", 8'h00, {7'h00, m_stuck});
    summarize();
  end

  // watchdog: a run far past its expected length counts as a failure
  initial begin
    repeat (40000) @(posedge clk_i);
    n_fail++;
    summarize();
  end
endmodule
